/* hw/lpwc_consts.vh */
// constants for the low-power wake control block
`ifndef LPWC_CONSTS_VH
`define LPWC_CONSTS_VH
`define LPWC_MODE_W 2
`define LPWC_MODE_ACTIVE 2'h0
`define LPWC_MODE_SLEEP 2'h1
`define LPWC_MODE_DSLEEP 2'h2
`define LPWC_MODE_DPD 2'h3
`define LPWC_ST_ACTIVE 4'h1
`define LPWC_ST_SLEEP 4'h2
`define LPWC_ST_DSLEEP 4'h4
`define LPWC_ST_DPD 4'h8
`define LPWC_NSRC 8
`define LPWC_SRC_PIN 0
`define LPWC_SRC_BOD 1
`define LPWC_SRC_WDT 2
`define LPWC_SRC_ALARM 3
`define LPWC_SRC_WAKE1K 4
`define LPWC_SRC_MICRO_TICK_TIMER 5
`define LPWC_SRC_SERIAL 6
`define LPWC_SRC_USB 7
`define LPWC_CAUSE_W 4
`define LPWC_CAUSE_NONE 4'h0
`define LPWC_CAUSE_IRQ 4'h1
`define LPWC_CAUSE_HARDWARE_WAKE_SIGNAL 4'h2
`define LPWC_CAUSE_DSLEEP 4'h3
`define LPWC_CAUSE_BODRST 4'h4
`define LPWC_CAUSE_WDTRST 4'h5
`define LPWC_CAUSE_RTC 4'h6
`define LPWC_CAUSE_PIN 4'h7
`endif

/* hw/lpwc_top.v */
// power-mode sequencing and wake-source qualification
`timescale 1ns/100ps
`include "lpwc_consts.vh"

// What this block does
// - deep power-down loses SRAM and registers; wake is a fresh reset
// - every functional pin floats while in deep power-down
// - alarm flag in deep power-down raises the rtc wake request and ends it
// - sleep ends on any interrupt enabled in the interrupt controller
// - hardware wake signal ends sleep and deep-sleep
// - pin interrupt wakes deep-sleep if enabled in controller and start-enable 0 or 1
// - brown-out interrupt wakes deep-sleep with controller, start-enable, brown-out enables
// - brown-out resets out of deep-sleep when its reset enable is set
// - watchdog interrupt wakes deep-sleep with osc, enable, feed and interrupt enables
// - watchdog time-out resets deep-sleep with osc, enable, reset enable and feed
// - 1 Hz alarm wakes deep-sleep once count written, enabled, bus clock on
// - 1 kHz wake timer wakes deep-sleep once started, both oscs on, enabled
// - in deep power-down the 1 Hz alarm wakes once osc on and count written
// - in deep power-down the 1 kHz timer wakes once started with both oscs on
// - micro-tick wakes deep-sleep with osc, bus clock, started and enabled
// - two-wire and four-wire serial wake deep-sleep only from slave-mode interrupts
// - serial port wakes deep-sleep only in synchronous slave or 32 kHz mode
// - usb clock-request interrupt wakes deep-sleep
module lpwc_top (
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_enter_req,
  input wire [1:0] i_enter_mode,
  input wire i_irq_pending,
  input wire i_hardware_wake_signal,
  input wire i_pin_irq,
  input wire i_pin_irq_processor_interrupt_controller_en,
  input wire i_pin_start_en_0,
  input wire i_pin_start_en_1,
  input wire i_bod_irq,
  input wire i_bod_irq_processor_interrupt_controller_en,
  input wire i_bod_start_en,
  input wire i_bod_ctrl_irq_en,
  input wire i_bod_keep_running,
  input wire i_bod_reset_event,
  input wire i_bod_ctrl_reset_en,
  input wire i_wdt_irq,
  input wire i_wdt_timeout,
  input wire i_wdt_osc_on,
  input wire i_wdt_enable,
  input wire i_wdt_fed,
  input wire i_wdt_mode_irq_en,
  input wire i_wdt_mode_reset_en,
  input wire i_wdt_processor_interrupt_controller_en,
  input wire i_wdt_start_en,
  input wire i_one_hz_alarm_flag,
  input wire i_alarm_count_written,
  input wire i_rtc_1hz_osc_on,
  input wire i_rtc_1khz_osc_on,
  input wire i_rtc_bus_clk_en,
  input wire i_alarm_start_en,
  input wire i_wake1k_flag,
  input wire i_wake1k_started,
  input wire i_wake1k_start_en,
  input wire i_micro_tick_timer_irq,
  input wire i_micro_tick_timer_bus_clk_en,
  input wire i_micro_tick_timer_started,
  input wire i_micro_tick_timer_start_en,
  input wire i_i2c_irq,
  input wire i_i2c_slave,
  input wire i_spi_irq,
  input wire i_spi_slave,
  input wire i_usart_irq,
  input wire i_usart_sync_slave,
  input wire i_usart_32k_mode,
  input wire i_usb_need_clk_irq,
  output reg [1:0] o_mode,
  output reg o_cpu_clk_en,
  output reg o_pll_en,
  output reg o_periph_clk_en,
  output reg o_wake_periph_clk_en,
  output reg o_flash_standby,
  output reg o_flash_on,
  output reg o_analog_on,
  output reg o_rtc_osc_keep,
  output reg o_pin_hiz_n,
  output reg o_retain_n,
  output reg o_chip_reset,
  output reg o_rtc_wake_irq,
  output reg o_wake_pulse,
  output reg [3:0] o_wake_cause
);

  // pins and peripheral events come from other domains: two flops before use
  localparam NSYNC = 46;
  wire [NSYNC-1:0] in_raw;
  reg [NSYNC-1:0] sync1_q;
  reg [NSYNC-1:0] sync2_q;
  assign in_raw = {i_enter_req, i_enter_mode, i_irq_pending, i_hardware_wake_signal,
    i_pin_irq, i_pin_irq_processor_interrupt_controller_en, i_pin_start_en_0, i_pin_start_en_1,
    i_bod_irq, i_bod_irq_processor_interrupt_controller_en, i_bod_start_en, i_bod_ctrl_irq_en, i_bod_keep_running,
    i_bod_reset_event, i_bod_ctrl_reset_en,
    i_wdt_irq, i_wdt_timeout, i_wdt_osc_on, i_wdt_enable, i_wdt_fed, i_wdt_mode_irq_en,
    i_wdt_mode_reset_en, i_wdt_processor_interrupt_controller_en, i_wdt_start_en,
    i_one_hz_alarm_flag, i_alarm_count_written, i_rtc_1hz_osc_on, i_rtc_1khz_osc_on,
    i_rtc_bus_clk_en, i_alarm_start_en, i_wake1k_flag, i_wake1k_started, i_wake1k_start_en,
    i_micro_tick_timer_irq, i_micro_tick_timer_bus_clk_en, i_micro_tick_timer_started, i_micro_tick_timer_start_en,
    i_i2c_irq, i_i2c_slave, i_spi_irq, i_spi_slave,
    i_usart_irq, i_usart_sync_slave, i_usart_32k_mode, i_usb_need_clk_irq};

  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      sync1_q <= {NSYNC{1'b0}};
      sync2_q <= {NSYNC{1'b0}};
    end else begin
      sync1_q <= in_raw;
      sync2_q <= sync1_q;
    end
  end

  wire enter_req, irq_pending, hw_wake, pin_irq, pin_processor_interrupt_controller, pin_se0, pin_se1;
  wire bod_irq, bod_processor_interrupt_controller, bod_se, bod_ctl_irq, bod_run, bod_rst, bod_ctl_rst;
  wire wdt_irq, wdt_to, wdt_osc, wdt_en, wdt_fed, wdt_mirq, wdt_mrst, wdt_processor_interrupt_controller, wdt_se;
  wire alarm_flag, alarm_cnt, osc_1hz, osc_1k, rtc_bus, alarm_se, w1k_flag, w1k_run, w1k_se;
  wire ut_irq, ut_bus, ut_run, ut_se, i2c_irq, i2c_slv, spi_irq, spi_slv;
  wire us_irq, us_sync, us_32k, usb_req;
  wire [1:0] enter_mode;
  assign {enter_req, enter_mode, irq_pending, hw_wake,
    pin_irq, pin_processor_interrupt_controller, pin_se0, pin_se1,
    bod_irq, bod_processor_interrupt_controller, bod_se, bod_ctl_irq, bod_run, bod_rst, bod_ctl_rst,
    wdt_irq, wdt_to, wdt_osc, wdt_en, wdt_fed, wdt_mirq, wdt_mrst, wdt_processor_interrupt_controller, wdt_se,
    alarm_flag, alarm_cnt, osc_1hz, osc_1k, rtc_bus, alarm_se, w1k_flag, w1k_run, w1k_se,
    ut_irq, ut_bus, ut_run, ut_se, i2c_irq, i2c_slv, spi_irq, spi_slv,
    us_irq, us_sync, us_32k, usb_req} = sync2_q;

  // deep-sleep wake qualification, one bit per source
  wire [`LPWC_NSRC-1:0] ds_src;
  assign ds_src[`LPWC_SRC_PIN] = pin_irq & pin_processor_interrupt_controller & (pin_se0 | pin_se1);
  assign ds_src[`LPWC_SRC_BOD] = bod_irq & bod_processor_interrupt_controller & bod_se & bod_ctl_irq & bod_run;
  assign ds_src[`LPWC_SRC_WDT] = wdt_irq & wdt_osc & wdt_en & wdt_fed & wdt_mirq
    & wdt_processor_interrupt_controller & wdt_se;
  assign ds_src[`LPWC_SRC_ALARM] = alarm_flag & alarm_cnt & osc_1hz & rtc_bus
    & alarm_se;
  assign ds_src[`LPWC_SRC_WAKE1K] = w1k_flag & w1k_run & osc_1hz & osc_1k & w1k_se;
  assign ds_src[`LPWC_SRC_MICRO_TICK_TIMER] = ut_irq & wdt_osc & ut_bus & ut_run & ut_se;
  assign ds_src[`LPWC_SRC_SERIAL] = (i2c_irq & i2c_slv) | (spi_irq & spi_slv)
    | (us_irq & (us_sync | us_32k));
  assign ds_src[`LPWC_SRC_USB] = usb_req;

  wire ds_wake = (|ds_src) | hw_wake;
  wire ds_reset = (bod_rst & bod_ctl_rst)
    | (wdt_to & wdt_osc & wdt_en & wdt_mrst & wdt_fed);
  wire dpd_alarm = alarm_flag & osc_1hz & alarm_cnt;
  wire dpd_1k = w1k_flag & w1k_run & osc_1hz & osc_1k;

  reg [3:0] state_q, state_d;
  reg [3:0] cause_d;
  reg wake_d, reset_d, rtc_irq_d;

  always @* begin
    state_d = state_q;
    cause_d = `LPWC_CAUSE_NONE;
    wake_d = 1'b0;
    reset_d = 1'b0;
    rtc_irq_d = 1'b0;
    case (state_q)
      `LPWC_ST_ACTIVE: begin
        if (enter_req) begin
          case (enter_mode)
            `LPWC_MODE_SLEEP: state_d = `LPWC_ST_SLEEP;
            `LPWC_MODE_DSLEEP: state_d = `LPWC_ST_DSLEEP;
            `LPWC_MODE_DPD: state_d = `LPWC_ST_DPD;
            default: state_d = `LPWC_ST_ACTIVE;
          endcase
        end
      end
      `LPWC_ST_SLEEP: begin
        if (irq_pending) begin
          state_d = `LPWC_ST_ACTIVE;
          wake_d = 1'b1;
          cause_d = `LPWC_CAUSE_IRQ;
        end else if (hw_wake) begin
          state_d = `LPWC_ST_ACTIVE;
          wake_d = 1'b1;
          cause_d = `LPWC_CAUSE_HARDWARE_WAKE_SIGNAL;
        end
      end
      `LPWC_ST_DSLEEP: begin
        // a reset source outranks a wake source seen in the same cycle
        if (ds_reset) begin
          state_d = `LPWC_ST_ACTIVE;
          reset_d = 1'b1;
          cause_d = (bod_rst & bod_ctl_rst) ? `LPWC_CAUSE_BODRST : `LPWC_CAUSE_WDTRST;
        end else if (ds_wake) begin
          state_d = `LPWC_ST_ACTIVE;
          wake_d = 1'b1;
          cause_d = ds_src[`LPWC_SRC_PIN] ? `LPWC_CAUSE_PIN : `LPWC_CAUSE_DSLEEP;
        end
      end
      `LPWC_ST_DPD: begin
        // leaving power-down is a full reset, never a resume
        if (dpd_alarm | dpd_1k) begin
          state_d = `LPWC_ST_ACTIVE;
          reset_d = 1'b1;
          rtc_irq_d = 1'b1;
          cause_d = `LPWC_CAUSE_RTC;
        end
      end
      default: state_d = `LPWC_ST_ACTIVE;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      state_q <= `LPWC_ST_ACTIVE;
      o_mode <= `LPWC_MODE_ACTIVE;
      o_cpu_clk_en <= 1'b1;
      o_pll_en <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_wake_periph_clk_en <= 1'b1;
      o_flash_standby <= 1'b0;
      o_flash_on <= 1'b1;
      o_analog_on <= 1'b1;
      o_rtc_osc_keep <= 1'b1;
      o_pin_hiz_n <= 1'b1;
      o_retain_n <= 1'b1;
      o_chip_reset <= 1'b0;
      o_rtc_wake_irq <= 1'b0;
      o_wake_pulse <= 1'b0;
      o_wake_cause <= `LPWC_CAUSE_NONE;
    end else begin
      state_q <= state_d;
      o_cpu_clk_en <= (state_d == `LPWC_ST_ACTIVE);
      o_pll_en <= (state_d == `LPWC_ST_ACTIVE) | (state_d == `LPWC_ST_SLEEP);
      o_periph_clk_en <= (state_d == `LPWC_ST_ACTIVE) | (state_d == `LPWC_ST_SLEEP);
      o_wake_periph_clk_en <= (state_d != `LPWC_ST_DPD);
      o_flash_standby <= (state_d == `LPWC_ST_DSLEEP);
      o_flash_on <= (state_d != `LPWC_ST_DPD);
      o_analog_on <= (state_d != `LPWC_ST_DPD);
      o_rtc_osc_keep <= 1'b1;
      o_pin_hiz_n <= (state_d != `LPWC_ST_DPD);
      o_retain_n <= (state_d != `LPWC_ST_DPD);
      o_chip_reset <= reset_d;
      o_rtc_wake_irq <= rtc_irq_d;
      o_wake_pulse <= wake_d;
      if (cause_d != `LPWC_CAUSE_NONE) begin
        o_wake_cause <= cause_d;
      end
      case (state_d)
        `LPWC_ST_SLEEP: o_mode <= `LPWC_MODE_SLEEP;
        `LPWC_ST_DSLEEP: o_mode <= `LPWC_MODE_DSLEEP;
        `LPWC_ST_DPD: o_mode <= `LPWC_MODE_DPD;
        default: o_mode <= `LPWC_MODE_ACTIVE;
      endcase
    end
  end

endmodule // lpwc_top

/* tb/lpwc_periph_model.sv */
// peripherals and interrupt controller model that drives the wake source levels
`timescale 1ns/100ps
module lpwc_periph_model (
  input wire i_ref_clk,
  input wire [42:0] i_cmd,
  input wire i_exit,
  output reg [42:0] o_src
);
  initial o_src = 43'h0;
  // requests stay up until the handler runs after wake; a chip reset wipes all enables
  always @(posedge i_ref_clk) begin
    if (i_exit) begin
      o_src <= 43'h0;
    end else begin
      o_src <= i_cmd;
    end
  end
endmodule // lpwc_periph_model

/* tb/lpwc_top_properties.sv */
// port assertions for the low-power wake control block
`timescale 1ns/100ps
module lpwc_checker (
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_usb_need_clk_irq,
  input wire [1:0] o_mode,
  input wire o_cpu_clk_en,
  input wire o_pll_en,
  input wire o_flash_standby,
  input wire o_pin_hiz_n,
  input wire o_retain_n,
  input wire o_chip_reset,
  input wire o_rtc_wake_irq,
  input wire o_wake_pulse,
  input wire [3:0] o_wake_cause
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  chk_pins_float: assert property (o_mode == 2'h3 |-> !o_pin_hiz_n)
    else $error("pins driven in power-down");
  chk_no_retain: assert property (o_mode == 2'h3 |-> !o_retain_n)
    else $error("retention kept in power-down");
  chk_dsleep_gate: assert property (o_mode == 2'h2 |-> o_flash_standby && !o_pll_en)
    else $error("deep-sleep gating wrong");
  chk_cpu_clock: assert property (o_cpu_clk_en == (o_mode == 2'h0))
    else $error("cpu clock enable wrong");
  chk_usb_wake: assert property (o_mode == 2'h2 && i_usb_need_clk_irq |-> ##[1:3] o_mode == 2'h0)
    else $error("usb request did not wake");
  chk_rtc_exit: assert property (o_rtc_wake_irq |-> o_chip_reset && o_wake_cause == 4'h6 && $past(o_mode) == 2'h3)
    else $error("rtc exit wrong");
  chk_reset_exit: assert property (o_chip_reset |-> o_mode == 2'h0 && $past(o_mode) >= 2'h2)
    else $error("chip reset outside deep modes");
  chk_wake_exit: assert property ($rose(o_wake_pulse) |-> o_mode == 2'h0 && $past(o_mode) != 2'h0 ##1 !o_wake_pulse)
    else $error("wake pulse wrong");
  chk_cause_hold: assert property (!o_wake_pulse && !o_chip_reset |-> $stable(o_wake_cause))
    else $error("wake cause moved without exit");
  cover property (o_rtc_wake_irq);
  cover property (o_mode == 2'h2 ##1 o_mode == 2'h0);
  cover property (o_chip_reset && o_wake_cause == 4'h5);
endmodule // lpwc_checker
bind lpwc_top lpwc_checker chk_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_usb_need_clk_irq(i_usb_need_clk_irq), .o_mode(o_mode), .o_cpu_clk_en(o_cpu_clk_en),
  .o_pll_en(o_pll_en), .o_flash_standby(o_flash_standby), .o_pin_hiz_n(o_pin_hiz_n),
  .o_retain_n(o_retain_n), .o_chip_reset(o_chip_reset), .o_rtc_wake_irq(o_rtc_wake_irq),
  .o_wake_pulse(o_wake_pulse), .o_wake_cause(o_wake_cause));

/* tb/test_lpwc_top.sv */
// self-checking bench for the low-power wake control block
`timescale 1ns/100ps
module test_lpwc_top;
  reg i_ref_clk = 1'b0;
  reg i_reset_n = 1'b0;
  reg i_enter_req = 1'b0;
  reg [1:0] i_enter_mode = 2'h0;
  reg [42:0] cmd = 43'h0;
  wire [42:0] s;
  wire [1:0] o_mode;
  wire [3:0] o_wake_cause;
  wire o_chip_reset, o_rtc_wake_irq, o_wake_pulse;
  wire [4:0] g;
  int n_mismatch = 0;
  int checked = 0;
  int md[5] = '{1, 2, 2, 2, 3};
  int lo[5] = '{0, 2, 13, 15, 22};
  int hi[5] = '{1, 12, 21, 42, 30};
  always #2.5 i_ref_clk = ~i_ref_clk;
  lpwc_periph_model periph (.i_ref_clk(i_ref_clk), .i_cmd(cmd), .i_exit(o_wake_pulse | o_chip_reset),
    .o_src(s));
  lpwc_top DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_enter_req(i_enter_req),
    .i_enter_mode(i_enter_mode), .i_irq_pending(s[0]), .i_hardware_wake_signal(s[1]),
    .i_pin_irq(s[2]), .i_pin_irq_processor_interrupt_controller_en(s[3]), .i_pin_start_en_0(s[4]), .i_pin_start_en_1(s[5]),
    .i_bod_irq(s[6]), .i_bod_irq_processor_interrupt_controller_en(s[7]), .i_bod_start_en(s[8]), .i_bod_ctrl_irq_en(s[9]),
    .i_bod_keep_running(s[10]), .i_bod_reset_event(s[11]), .i_bod_ctrl_reset_en(s[12]),
    .i_wdt_irq(s[13]), .i_wdt_timeout(s[14]), .i_wdt_osc_on(s[15]), .i_wdt_enable(s[16]),
    .i_wdt_fed(s[17]), .i_wdt_mode_irq_en(s[18]), .i_wdt_mode_reset_en(s[19]),
    .i_wdt_processor_interrupt_controller_en(s[20]), .i_wdt_start_en(s[21]), .i_one_hz_alarm_flag(s[22]),
    .i_alarm_count_written(s[23]), .i_rtc_1hz_osc_on(s[24]), .i_rtc_1khz_osc_on(s[25]),
    .i_rtc_bus_clk_en(s[26]), .i_alarm_start_en(s[27]), .i_wake1k_flag(s[28]),
    .i_wake1k_started(s[29]), .i_wake1k_start_en(s[30]), .i_micro_tick_timer_irq(s[31]),
    .i_micro_tick_timer_bus_clk_en(s[32]), .i_micro_tick_timer_started(s[33]), .i_micro_tick_timer_start_en(s[34]),
    .i_i2c_irq(s[35]), .i_i2c_slave(s[36]), .i_spi_irq(s[37]), .i_spi_slave(s[38]),
    .i_usart_irq(s[39]), .i_usart_sync_slave(s[40]), .i_usart_32k_mode(s[41]),
    .i_usb_need_clk_irq(s[42]), .o_mode(o_mode), .o_cpu_clk_en(), .o_pll_en(),
    .o_periph_clk_en(g[4]), .o_wake_periph_clk_en(g[3]), .o_flash_standby(),
    .o_flash_on(g[2]), .o_analog_on(g[1]), .o_rtc_osc_keep(g[0]), .o_pin_hiz_n(),
    .o_retain_n(),
    .o_chip_reset(o_chip_reset), .o_rtc_wake_irq(o_rtc_wake_irq), .o_wake_pulse(o_wake_pulse),
    .o_wake_cause(o_wake_cause));
  task automatic chk(string what, logic [3:0] seen, logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // resets win over wake sources; a pin source is reported apart from the others
  function automatic logic [3:0] model(int m, logic [42:0] v);
    if (m == 1) return v[0] ? 4'h1 : (v[1] ? 4'h2 : 4'h0);
    if (m == 3) return (v[22] & v[23] & v[24] | v[24] & v[25] & v[28] & v[29]) ? 4'h6 : 4'h0;
    if (v[11] & v[12]) return 4'h4;
    if (v[14] & (&v[17:15]) & v[19]) return 4'h5;
    if (v[2] & v[3] & (v[4] | v[5])) return 4'h7;
    if ((&v[10:6]) | v[13] & (&v[18:15]) & (&v[21:20]) | (&v[24:22]) & (&v[27:26])
        | v[24] & v[25] & (&v[30:28]) | v[15] & (&v[34:31]) | (&v[36:35]) | (&v[38:37])
        | v[39] & (v[40] | v[41]) | v[42]) return 4'h3;
    return 4'h0;
  endfunction
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
  initial begin
    int m;
    int k;
    logic [3:0] e;
    logic [63:0] r;
    void'($urandom(32'h2FAB20CA));
    repeat (3) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    i_enter_req = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    chk("refused entry", {2'h0, o_mode}, 4'h0);
    for (int i = 0; i < 40; i++) begin
      m = md[i % 5];
      i_enter_req = 1'b1;
      i_enter_mode = m[1:0];
      k = 0;
      while (o_mode !== m[1:0] && k < 8) begin
        @(negedge i_ref_clk);
        k++;
      end
      i_enter_req = 1'b0;
      chk("entry", {2'h0, o_mode}, m[3:0]);
      chk("gating", g[4:1], {m < 2, m != 3, m != 3, m != 3});
      chk("rtc osc", {3'h0, g[0]}, 4'h1);
      // bias each bit toward one so whole qualifier sets line up often
      r = {~($urandom & $urandom & $urandom), ~($urandom & $urandom & $urandom)};
      cmd = r[42:0] & ((43'h1 << (hi[i % 5] + 1)) - (43'h1 << lo[i % 5]));
      e = model(m, cmd);
      repeat (4) @(negedge i_ref_clk);
      cmd = 43'h0;
      if (e == 4'h0) begin
        chk("stay", {2'h0, o_mode}, m[3:0]);
        i_reset_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        i_reset_n = 1'b1;
        chk("cleared cause", o_wake_cause, 4'h0);
      end else begin
        chk("exit mode", {2'h0, o_mode}, 4'h0);
        chk("gating back", g[4:1], 4'hF);
        chk("cause", o_wake_cause, e);
        chk("pulses", {1'b0, o_rtc_wake_irq, o_wake_pulse, o_chip_reset},
          (e == 4'h6) ? 4'h5 : ((e == 4'h4 || e == 4'h5) ? 4'h1 : 4'h2));
      end
      $display("test %0d mode %0d cause %0d done", i, m, e);
    end
    close_out();
  end
endmodule // test_lpwc_top
